// *** hdl/pt_totalizer.sv ***
// process totalizer: timed accumulation of the scaled reading

// Overview of operation
// RQ1 - total accumulates reading times multiplier and period
// RQ2 - update once every 400 ms tick
// RQ3 - period codes 0,1,2 mean second, minute, hour
// RQ4 - unit multiplier adds reading once per period
// RQ5 - multiplier scales every increment proportionally
// RQ6 - total decimal point independent, zero to four
// RQ7 - clear from remote, panel or serial
// RQ8 - nonnegative threshold: below it, accumulation stops
// RQ9 - negative threshold: between it and zero, decrement
// RQ10 - negative threshold: positive adds, below threshold stops
// RQ11 - total saved at power loss, restored later
// RQ12 - six-digit range, wrap with flashing overflow
// RQ13 - reversed input unwinds wrap, overflow clears
// RQ14 - total for alarms, changes only at tick
// RQ15 - panel clear is up held plus program
// RQ16 - fractional remainder kept between ticks
module pt_totalizer #(
   parameter int TICK_CYCLES = pt_pkg::TICK_CYCLES,
   parameter int ACK_CYCLES  = pt_pkg::ACK_CYCLES
) (
   input  wire logic                             i_ref_clk,
   input  wire logic                             i_resetn,
   input  wire logic signed [pt_pkg::READ_W-1:0] i_reading,
   input  wire pt_pkg::pt_cfg_s                  i_cfg,
   input  wire logic                             i_run,
   input  wire logic                             i_remote_clear_pin,
   input  wire logic                             i_panel_up_pin,
   input  wire logic                             i_panel_prog_pin,
   input  wire logic                             i_serial_clear,
   input  wire logic                             i_restore,
   input  wire logic signed [pt_pkg::TOT_W-1:0]  i_restore_total,
   output logic signed [pt_pkg::TOT_W-1:0]       o_total,
   output logic                                  o_overflow,
   output logic                                  o_overflow_blink,
   output logic                                  o_tick,
   output logic                                  o_clear_ack,
   output logic [2:0]                            o_point_pos
);

   // ***************************************************
   // local widths and elaboration checks
   // ***************************************************
   localparam int NW = pt_pkg::NUM_W;
   localparam int DW = pt_pkg::DEN_W;
   localparam int SW = pt_pkg::NUM_W + 1;   // width of the applied sum
   localparam int TOT_W = pt_pkg::TOT_W;    // width of the running total

   // the divider needs NUM_W cycles inside one tick
   if (TICK_CYCLES < 2 * pt_pkg::NUM_W || ACK_CYCLES < 1) begin : g_chk
      $error("pt_totalizer: tick or acknowledge count too small");
   end

   // ***************************************************
   // state and combinational helpers
   // ***************************************************
   pt_pkg::pt_state_s       s_q;          // registered state
   pt_pkg::pt_state_s       s_d;          // next state
   logic                    tick_now;     // 400 ms enable pulse
   logic                    remote_rise;  // remote clear edge
   logic                    panel_clear;  // up held, program pressed
   logic                    clr_now;      // any clear source
   logic                    below_cut;    // reading under threshold
   logic                    start_now;    // launch a tick update
   logic                    restore_ok;   // restore value in range
   logic signed [NW-1:0]    num;          // remainder plus new slice
   logic [DW-1:0]           den_sel;      // divisor for the period
   logic [DW:0]             part_sh;      // shifted partial remainder
   logic                    part_ge;      // subtract fits
   logic signed [SW-1:0]    step;         // signed whole increment
   logic signed [SW-1:0]    sum;          // total plus increment
   logic signed [DW:0]      rem_nx;       // signed leftover fraction

   assign tick_now    = (s_q.tick_cnt == 32'(TICK_CYCLES - 1));
   // only the second sync stage and the edge flop are looked at
   assign remote_rise = s_q.remote_sync[1] & ~s_q.remote_prev;
   assign panel_clear = s_q.prog_sync[1] & ~s_q.prog_prev
                        & s_q.up_sync[1];              // see RQ15
   assign clr_now     = remote_rise | panel_clear
                        | i_serial_clear;              // see RQ7
   // one compare covers both signs of the threshold
   assign below_cut   = (i_reading < i_cfg.low_signal_threshold); // see RQ8
   assign start_now   = tick_now && (s_q.phase == pt_pkg::PT_IDLE)
                        && i_run && !below_cut;        // see RQ14
   assign restore_ok  = (i_restore_total <= TOT_W'(pt_pkg::TOTAL_MAX))
                        && (i_restore_total >= TOT_W'(pt_pkg::TOTAL_MIN));

   // numerator: reading times multiplier plus carried fraction
   // the product is kept at full width; only the divider truncates
   assign num = NW'(i_reading) * NW'($signed({1'b0, i_cfg.total_multiplier}))
                + NW'(s_q.rem);                        // see RQ1, RQ5, RQ16

   // divisor per tick for the selected period
   always_comb begin
      unique case (i_cfg.period_sel)
         pt_pkg::PER_MIN:  den_sel = DW'(pt_pkg::DEN_MIN);  // see RQ3
         pt_pkg::PER_HOUR: den_sel = DW'(pt_pkg::DEN_HOUR); // see RQ3
         default:          den_sel = DW'(pt_pkg::DEN_SEC);  // see RQ3, RQ4
      endcase
   end

   // one restoring division step per clock
   assign part_sh = {s_q.part[DW-1:0], s_q.quo[NW-1]};
   assign part_ge = (part_sh >= {1'b0, s_q.den});

   // signed increment and fraction after the division
   assign step   = s_q.neg ? -$signed({1'b0, s_q.quo})
                           : $signed({1'b0, s_q.quo}); // see RQ9
   assign rem_nx = s_q.neg ? -$signed({1'b0, s_q.part[DW-1:0]})
                           : $signed({1'b0, s_q.part[DW-1:0]});
   assign sum    = step + SW'(s_q.total);

   // ***************************************************
   // next-state logic
   // ***************************************************
   always_comb begin
      s_d      = s_q;
      s_d.tick = tick_now;
      // free-running tick divider
      if (tick_now) begin
         s_d.tick_cnt = '0;                            // see RQ2
      end else begin
         s_d.tick_cnt = s_q.tick_cnt + 32'h1;
      end
      // two-flop synchronisers for the pins, edge flops for remote and program only
      s_d.remote_sync = {s_q.remote_sync[0], i_remote_clear_pin};
      s_d.remote_prev = s_q.remote_sync[1];
      s_d.up_sync     = {s_q.up_sync[0], i_panel_up_pin};
      s_d.prog_sync   = {s_q.prog_sync[0], i_panel_prog_pin};
      s_d.prog_prev   = s_q.prog_sync[1];
      // update sequencer
      unique case (s_q.phase)
         pt_pkg::PT_IDLE: begin
            if (start_now) begin                       // see RQ1, RQ10
               s_d.neg     = num[NW-1];
               s_d.quo     = num[NW-1] ? NW'(-num) : NW'(num);
               s_d.part    = '0;
               s_d.den     = den_sel;
               s_d.bit_cnt = '0;
               s_d.phase   = pt_pkg::PT_DIV;
            end
         end
         pt_pkg::PT_DIV: begin
            s_d.part = part_ge ? part_sh - {1'b0, s_q.den} : part_sh;
            s_d.quo  = {s_q.quo[NW-2:0], part_ge};
            s_d.bit_cnt = s_q.bit_cnt + 6'h1;
            if (s_q.bit_cnt == 6'(NW - 1)) begin
               s_d.phase = pt_pkg::PT_APPLY;
            end
         end
         pt_pkg::PT_APPLY: begin
            s_d.rem   = rem_nx;                        // see RQ16
            s_d.phase = pt_pkg::PT_IDLE;
            // wrap on the six-digit modulus and count the wraps
            // only one wrap per update: a step beyond the modulus would
            // leave the total outside its six digits
            if (sum > SW'(pt_pkg::TOTAL_MAX)) begin     // see RQ12
               s_d.total = TOT_W'(sum - SW'(pt_pkg::TOTAL_SPAN));
               s_d.wraps = s_q.wraps + 8'sh01;
            end else if (sum < SW'(pt_pkg::TOTAL_MIN)) begin
               s_d.total = TOT_W'(sum + SW'(pt_pkg::TOTAL_SPAN));
               s_d.wraps = s_q.wraps - 8'sh01;         // see RQ13
            end else begin
               s_d.total = TOT_W'(sum);
            end
         end
      endcase
      // restore is refused while an update is in flight, so a stale
      // increment can never land on top of a freshly loaded total
      // clear wins over any update in flight
      if (clr_now) begin                               // see RQ7
         s_d.total = '0;
         s_d.rem   = '0;
         s_d.wraps = '0;
         s_d.phase = pt_pkg::PT_IDLE;
      end else if (i_restore && restore_ok
                   && s_q.phase == pt_pkg::PT_IDLE) begin
         s_d.total = i_restore_total;                  // see RQ11
         s_d.rem   = '0;
         s_d.wraps = '0;
         s_d.phase = pt_pkg::PT_IDLE;
      end
      // acknowledge after a clear
      // a new clear restarts the count, so back-to-back clears stretch it
      if (clr_now) begin
         s_d.ack_cnt = 32'(ACK_CYCLES - 1);
         s_d.ack     = 1'b1;
      end else if (s_q.ack_cnt != '0) begin
         s_d.ack_cnt = s_q.ack_cnt - 32'h1;
      end else begin
         s_d.ack     = 1'b0;
      end
      // overflow flag and its flash phase
      s_d.ovf = (s_d.wraps != '0);                     // see RQ12, RQ13
      if (!s_d.ovf) begin
         s_d.blink = 1'b0;
      end else if (tick_now) begin
         s_d.blink = ~s_q.blink;
      end
      // decimal point, limited to four places
      s_d.point = (i_cfg.point_pos > pt_pkg::POINT_MAX)
                  ? pt_pkg::POINT_MAX : i_cfg.point_pos; // see RQ6
   end

   // ***************************************************
   // state register
   // ***************************************************
   // synchronous reset; the phase must wake up as a legal one-hot code
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         s_q       <= '0;
         s_q.phase <= pt_pkg::PT_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state flops
   assign o_total          = s_q.total;                // see RQ14
   assign o_overflow       = s_q.ovf;
   assign o_overflow_blink = s_q.blink;
   assign o_tick           = s_q.tick;
   assign o_clear_ack      = s_q.ack;
   assign o_point_pos      = s_q.point;

   // ***************************************************
   // assertions
   // ***************************************************
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);

   // helper counter, so tick spacing needs no long repetition
   logic [31:0] gap_q;      // cycles since the last tick
   logic        seen_q;     // a tick has been seen
   logic        in_apply;   // sequencer applying an increment
   assign in_apply = (s_q.phase == pt_pkg::PT_APPLY);
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         gap_q  <= '0;
         seen_q <= 1'b0;
      end else begin
         gap_q  <= o_tick ? 32'h0 : gap_q + 32'h1;
         seen_q <= seen_q | o_tick;
      end
   end

   AST_TICK_SPACING: assert property ( // see RQ2
      (o_tick && seen_q) |-> gap_q == 32'(TICK_CYCLES - 1))
      else $error("tick spacing wrong");
   AST_SERIAL_CLEAR: assert property ( // see RQ7
      i_serial_clear |=> (o_total == '0) && !o_overflow && o_clear_ack)
      else $error("serial clear not applied");
   AST_REMOTE_CLEAR: assert property ( // see RQ7
      $rose(i_remote_clear_pin) ##1 i_remote_clear_pin ##1 1'b1
      |=> o_total == '0)
      else $error("remote clear not applied");
   AST_HOLD_BELOW: assert property ( // see RQ8
      (tick_now && below_cut && s_q.phase == pt_pkg::PT_IDLE)
      |=> s_q.phase == pt_pkg::PT_IDLE)
      else $error("accumulated below threshold");
   AST_START: assert property ( // see RQ10
      (start_now && !clr_now && !i_restore) |=> s_q.phase == pt_pkg::PT_DIV)
      else $error("tick update not started");
   AST_PERIOD_DEN: assert property ( // see RQ3
      (start_now && i_cfg.period_sel == pt_pkg::PER_HOUR && !clr_now
       && !i_restore) |=> s_q.den == DW'(pt_pkg::DEN_HOUR))
      else $error("hour divisor wrong");
   AST_DIV_DONE: assert property ( // see RQ4
      $rose(s_q.phase == pt_pkg::PT_DIV)
      |-> ##[1:40] (s_q.phase != pt_pkg::PT_DIV))
      else $error("division does not finish");
   AST_DECREMENT: assert property ( // see RQ9
      (in_apply && s_q.neg && !clr_now)
      |=> (o_total <= $past(o_total)) || $changed(s_q.wraps))
      else $error("negative increment raised total");
   AST_RANGE: assert property ( // see RQ12
      (o_total <= TOT_W'(pt_pkg::TOTAL_MAX))
      && (o_total >= TOT_W'(pt_pkg::TOTAL_MIN)))
      else $error("total outside six digits");
   AST_WRAP_MOVES: assert property ( // see RQ13
      $changed(s_q.wraps) && !$past(clr_now) && !$past(i_restore)
      |-> $past(in_apply))
      else $error("wrap count moved outside an update");
   AST_ONLY_AT_UPDATE: assert property ( // see RQ14
      $changed(o_total) |-> $past(in_apply) || $past(clr_now)
                            || $past(i_restore))
      else $error("total changed off the tick path");
   AST_RESTORE: assert property ( // see RQ11
      (i_restore && restore_ok && !clr_now
       && s_q.phase == pt_pkg::PT_IDLE)
      |=> o_total == $past(i_restore_total))
      else $error("restore value not loaded");
   AST_POINT: assert property ( // see RQ6
      o_point_pos <= pt_pkg::POINT_MAX)
      else $error("decimal point out of range");

   COV_APPLY: cover property (in_apply ##1 o_total != '0);
   COV_WRAP:  cover property ($rose(o_overflow));
   COV_PANEL: cover property (panel_clear ##1 o_clear_ack);
   COV_UNWRAP: cover property ($fell(o_overflow) && !$past(clr_now));

endmodule

// *** shared/pt_pkg.sv ***
// shared constants, types and state layout of the process totalizer
package pt_pkg;

   // ***************************************************
   // clock and timing
   // ***************************************************
   localparam int CLK_HZ     = 20_000_000;  // reference clock rate
   localparam int TICK_MS    = 400;         // accumulation update period
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int ACK_MS     = 1000;        // clear acknowledge length
   localparam int ACK_CYCLES = CLK_HZ / 1000 * ACK_MS;

   // ***************************************************
   // scaling
   // ***************************************************
   localparam int MULT_ONE   = 1000;        // multiplier code for 1.000
   localparam int PERIOD_SEC_S  = 1;        // seconds per period
   localparam int PERIOD_MIN_S  = 60;
   localparam int PERIOD_HOUR_S = 3600;
   // divisor per tick = multiplier unit * ticks per second * period
   localparam int DEN_UNIT   = MULT_ONE * 1000 / TICK_MS;
   localparam int DEN_SEC    = DEN_UNIT * PERIOD_SEC_S;
   localparam int DEN_MIN    = DEN_UNIT * PERIOD_MIN_S;
   localparam int DEN_HOUR   = DEN_UNIT * PERIOD_HOUR_S;
   localparam logic [1:0] PER_SEC  = 2'h0;  // accumulation period codes
   localparam logic [1:0] PER_MIN  = 2'h1;
   localparam logic [1:0] PER_HOUR = 2'h2;

   // ***************************************************
   // total range and widths
   // ***************************************************
   localparam int TOTAL_MAX  = 999999;      // highest shown total
   localparam int TOTAL_MIN  = -99999;      // lowest shown total
   localparam int TOTAL_SPAN = 1000000;     // six-digit wrap modulus
   localparam logic [2:0] POINT_MAX = 3'h4; // four decimals at most
   localparam int READ_W = 20;              // scaled reading width
   localparam int MULT_W = 16;              // multiplier width
   localparam int TOT_W  = 21;              // total width
   localparam int DEN_W  = 24;              // divisor width
   localparam int NUM_W  = 38;              // per-tick numerator width

   // ***************************************************
   // types
   // ***************************************************
   typedef enum logic [2:0] {
      PT_IDLE  = 3'b001,
      PT_DIV   = 3'b010,
      PT_APPLY = 3'b100
   } pt_phase_e;

   // configuration group from the setup logic
   typedef struct packed {
      logic [1:0]               period_sel;  // accumulation_period_select
      logic [2:0]               point_pos;   // total_point_position
      logic signed [READ_W-1:0] low_signal_threshold;
      logic [MULT_W-1:0]        total_multiplier; // 1000 = 1.000
   } pt_cfg_s;

   // whole state of the totalizer
   typedef struct packed {
      logic [31:0]              tick_cnt;
      logic [31:0]              ack_cnt;
      logic [1:0]               remote_sync;
      logic                     remote_prev;
      logic [1:0]               up_sync;
      logic [1:0]               prog_sync;
      logic                     prog_prev;
      pt_phase_e                phase;
      logic                     neg;
      logic [NUM_W-1:0]         quo;
      logic [DEN_W:0]           part;
      logic [DEN_W-1:0]         den;
      logic [5:0]               bit_cnt;
      logic signed [DEN_W:0]    rem;
      logic signed [TOT_W-1:0]  total;
      logic signed [7:0]        wraps;
      logic                     ovf;
      logic                     blink;
      logic                     tick;
      logic                     ack;
      logic [2:0]               point;
   } pt_state_s;

endpackage

// *** sim/pt_input_model.sv ***
// partner model of the scaled measurement stage feeding the totalizer
module pt_input_model (
   input  wire logic                             i_ref_clk,
   input  wire logic                             i_resetn,
   input  wire logic signed [pt_pkg::READ_W-1:0] i_level,
   output logic signed [pt_pkg::READ_W-1:0]      o_reading
);
   timeunit 1ns;
   timeprecision 1ps;

   // ***************************************************
   // measurement register
   // ***************************************************
   // a new conversion lands one clock after the commanded level changes,
   // so the reading only moves on an edge, as a real scaler output does
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         o_reading <= '0;                 // no measurement before reset ends
      end else begin
         o_reading <= i_level;            // latest scaled reading
      end
   end
endmodule

// *** sim/tb_pt_totalizer.sv ***
// self-checking testbench of the process totalizer
module tb_pt_totalizer;
   timeunit 1ns;
   timeprecision 1ps;

   // ***************************************************
   // stimulus and observation signals
   // ***************************************************
   localparam int TC = 100;               // shortened tick period
   localparam int AC = 20;                // shortened acknowledge length
   logic                             clk;
   logic                             rstn;
   logic signed [pt_pkg::READ_W-1:0] level;       // commanded reading
   logic signed [pt_pkg::READ_W-1:0] reading;     // from the model
   pt_pkg::pt_cfg_s                  cfg;
   logic                             run, remote, up, prog, ser, rst_req;
   logic signed [pt_pkg::TOT_W-1:0]  rst_val;
   logic signed [pt_pkg::TOT_W-1:0]  o_total;
   logic                             o_ovf, o_blink, o_tick, o_ack;
   logic [2:0]                       o_point;
   int                               err_total, checks_done;
   longint                           exp_tot, rem;  // reference total
   int                               wraps;         // reference wraps
   logic                             blink_prev;

   // ***************************************************
   // clock, partner and design
   // ***************************************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;              // 20 MHz
   end

   pt_input_model src_u (.i_ref_clk(clk), .i_resetn(rstn), .i_level(level),
                         .o_reading(reading));

   pt_totalizer #(.TICK_CYCLES(TC), .ACK_CYCLES(AC)) dut_u (
      .i_ref_clk(clk), .i_resetn(rstn), .i_reading(reading), .i_cfg(cfg),
      .i_run(run), .i_remote_clear_pin(remote), .i_panel_up_pin(up),
      .i_panel_prog_pin(prog), .i_serial_clear(ser), .i_restore(rst_req),
      .i_restore_total(rst_val), .o_total(o_total), .o_overflow(o_ovf),
      .o_overflow_blink(o_blink), .o_tick(o_tick), .o_clear_ack(o_ack),
      .o_point_pos(o_point));

   // ***************************************************
   // shared tasks
   // ***************************************************
   // compare and count
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // closing counts and verdict
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // wait n ticks, predicting each update from the inputs held meanwhile
   task automatic run_ticks(input int n);
      logic   moved;
      longint den, num, inc, sum;
      for (int k = 0; k < n; k++) begin
         moved = 1'b0;
         for (int c = 0; c <= 3 * TC && o_tick !== 1'b1; c++) begin
            @(negedge clk);
            if (o_total !== exp_tot[20:0]) moved = 1'b1;
         end
         check(o_tick, 1'b1);
         check(moved, 1'b0);
         case (cfg.period_sel)
            2'h1:    den = pt_pkg::DEN_MIN;
            2'h2:    den = pt_pkg::DEN_HOUR;
            default: den = pt_pkg::DEN_SEC;
         endcase
         if (run && level >= cfg.low_signal_threshold) begin
            num = longint'(level) * cfg.total_multiplier + rem;
            inc = num / den;
            rem = num - inc * den;
            sum = exp_tot + inc;
            if (sum > pt_pkg::TOTAL_MAX) begin
               sum = sum - pt_pkg::TOTAL_SPAN;
               wraps++;
            end else if (sum < pt_pkg::TOTAL_MIN) begin
               sum = sum + pt_pkg::TOTAL_SPAN;
               wraps--;
            end
            exp_tot = sum;
         end
         repeat (45) @(negedge clk);
         check(o_total, exp_tot);
         check(o_ovf, wraps != 0);
      end
   endtask

   // load a saved total as after a power cycle
   task automatic restore(input longint v);
      @(posedge clk);
      rst_req <= 1'b1;
      rst_val <= v[20:0];
      @(posedge clk);
      rst_req <= 1'b0;
      repeat (2) @(negedge clk);
      exp_tot = v;
      rem = 0;
      wraps = 0;
      check(o_total, v);
   endtask

   // clear from serial (0), remote pin (1) or panel buttons (2)
   task automatic clear_from(input int from);
      @(posedge clk);
      case (from)
         0: ser <= 1'b1;
         1: remote <= 1'b1;
         default: begin
            up <= 1'b1;
            repeat (4) @(posedge clk);
            prog <= 1'b1;
         end
      endcase
      @(posedge clk);
      ser <= 1'b0;
      repeat (8) @(negedge clk);
      check(o_total, 0);
      check(o_ack, 1'b1);
      check(o_ovf, 1'b0);
      @(posedge clk);
      remote <= 1'b0;
      prog <= 1'b0;
      up <= 1'b0;
      repeat (AC + 4) @(negedge clk);
      check(o_ack, 1'b0);
      exp_tot = 0;
      rem = 0;
      wraps = 0;
   endtask

   // ***************************************************
   // test sequence
   // ***************************************************
   initial begin
      rstn = 1'b0;
      level = '0;
      cfg = '{period_sel: 2'h0, point_pos: 3'h0,
              low_signal_threshold: 20'sh0, total_multiplier: 16'h3E8};
      {run, remote, up, prog, ser, rst_req} = 6'h20;
      rst_val = '0;
      {err_total, checks_done, exp_tot, rem, wraps} = '0;
      repeat (16) @(negedge clk);
      check({o_total, o_ovf, o_blink, o_tick, o_ack, o_point}, 0);
      @(posedge clk);
      rstn <= 1'b1;
      $display("test reset done");
      // per second, unit multiplier: two periods add twice the reading
      level <= 20'sh9C4;
      run_ticks(5);
      check(o_total, 64'h1388);
      $display("test unit period done");
      // each period code; only the minute code leaves a fractional step per tick
      for (int p = 0; p < 3; p++) begin
         restore(0);
         @(posedge clk);
         cfg.period_sel <= p[1:0];
         level <= (p == 2) ? 20'sh15F90 : 20'sh3E8;
         run_ticks(3);
      end
      $display("test periods done");
      restore(0);
      @(posedge clk);
      cfg.period_sel <= pt_pkg::PER_SEC;
      cfg.total_multiplier <= 16'h9C4;
      level <= 20'sh3E8;
      run_ticks(2);
      $display("test multiplier done");
      @(posedge clk);
      cfg.low_signal_threshold <= 20'sh1F4;
      level <= 20'sh190;
      run_ticks(2);
      level <= 20'sh258;
      run_ticks(1);
      @(posedge clk);
      cfg.low_signal_threshold <= -20'sh64;
      level <= -20'sh32;
      run_ticks(2);
      level <= -20'shC8;
      run_ticks(1);
      level <= 20'sh64;
      run_ticks(1);
      @(posedge clk);
      run <= 1'b0;
      run_ticks(1);
      @(posedge clk);
      run <= 1'b1;
      $display("test threshold done");
      restore(999000);
      level <= 20'sh258;
      run_ticks(2);
      blink_prev = o_blink;
      run_ticks(1);
      check(o_blink, !blink_prev);
      // widen the cutout so the reversed reading is not held
      @(posedge clk);
      cfg.low_signal_threshold <= -20'sh10000;
      level <= -20'shEA60;
      run_ticks(2);
      check(o_blink, 1'b0);
      $display("test overflow done");
      for (int s = 0; s < 3; s++) begin
         clear_from(s);
         level <= 20'sh5;
         run_ticks(1);
      end
      $display("test clear done");
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         cfg.point_pos <= i[2:0];
         repeat (2) @(negedge clk);
         check(o_point, (i > 4) ? 4 : i);
      end
      $display("test point done");
      print_verdict();
   end

   // ***************************************************
   // watchdog
   // ***************************************************
   initial begin
      repeat (40000) @(posedge clk);
      err_total++;
      print_verdict();
   end
endmodule
